// File: rtl/pss_pkg.sv
// constants and types for the pulse superposition and positioning block
package pss_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned RAMP_UNIT_MS = 10;
    localparam int unsigned RATE_PER_PULSE = 10;
    localparam int unsigned ACC_W = 21;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SUPVAL = 8'h04;
    localparam logic [7:0] OFF_SUPRATE = 8'h08;
    localparam logic [7:0] OFF_ACCTIME = 8'h0C;
    localparam logic [7:0] OFF_DECTIME = 8'h10;
    localparam logic [7:0] OFF_ARRHOLD = 8'h14;
    localparam logic [7:0] OFF_CMPHOLD = 8'h18;
    localparam logic [7:0] OFF_FILTTC = 8'h1C;
    localparam logic [7:0] OFF_ENCCLR = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_SPEED = 8'h28;
    localparam logic [7:0] OFF_ENCCNT = 8'h2C;
    // control fields
    localparam int CTRL_PULSE_REF = 0;
    localparam int CTRL_POS_MODE = 1;
    localparam int CTRL_SRC_LO = 2;
    localparam logic [1:0] SRC_MAIN = 2'h0;
    localparam logic [1:0] SRC_CARD = 2'h1;
    localparam logic [1:0] SRC_HYBRID = 2'h2;
    // status fields
    localparam int ST_SUPER = 0;
    localparam int ST_STATE_LO = 1;
    localparam int ST_POSDONE = 4;
    localparam int ST_ORIDONE = 5;
    localparam int ST_PEND_LO = 16;
    // ranges and reset values
    localparam int SUPVAL_MIN = -9999;
    localparam int SUPVAL_MAX = 32767;
    localparam int RATE_MAX = 30000;
    localparam int RAMP_MIN = 1;
    localparam int RAMP_MAX = 30000;
    localparam int HOLD_MAX = 60000;
    localparam int FILT_MAX = 32000;
    localparam int PEND_LIM = 65535;
    localparam logic [14:0] RST_SUPRATE = 15'h0050;
    localparam logic [14:0] RST_ACCTIME = 15'h012C;
    localparam logic [14:0] RST_DECTIME = 15'h012C;
    localparam logic [15:0] RST_ARRHOLD = 16'h0064;
    localparam logic [15:0] RST_CMPHOLD = 16'h00C8;
    localparam logic [15:0] RST_FILTTC = 16'h0064;
    // synchronised pin indices
    localparam int IN_REF = 0;
    localparam int IN_REFDIR = 1;
    localparam int IN_CARD = 2;
    localparam int IN_CARDDIR = 3;
    localparam int IN_ONESHOT = 4;
    localparam int IN_INC = 5;
    localparam int IN_DEC = 6;
    localparam int IN_START = 7;
    localparam int IN_TARGET = 8;
    localparam int IN_ORIENT = 9;
    localparam int IN_ENCCLR = 10;
    localparam int IN_W = 11;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        POS_IDLE,
        POS_ACCEL,
        POS_RUN,
        POS_DECEL,
        POS_ARRIVE,
        POS_COMPLETE
    } pss_pos_t;
endpackage : pss_pkg

// File: rtl/pss_core.sv
// pulse superposition, positioning timing and register slave
`timescale 1ns/1ps
module pss_core #(
    parameter int unsigned MS_CYCLES = pss_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pulse reference and option card inputs
    input wire logic refPulse,
    input wire logic refDir,
    input wire logic cardPulse,
    input wire logic cardDir,
    // terminals
    input wire logic termOneShot,
    input wire logic termIncrease,
    input wire logic termDecrease,
    input wire logic posStart,
    input wire logic targetReached,
    input wire logic orientDone,
    input wire logic encClear,
    // outputs
    output logic mergedStep,
    output logic mergedDir,
    output logic superposing,
    output logic posComplete,
    output logic orientComplete
);
    localparam int unsigned FULL = MS_CYCLES * pss_pkg::RATE_PER_PULSE;

    typedef struct packed {
        logic [pss_pkg::IN_W-1:0] s1;
        logic [pss_pkg::IN_W-1:0] s2;
        logic [pss_pkg::IN_W-1:0] s3;
        logic awReady;
        logic wReady;
        logic arReady;
        logic awHeld;
        logic wHeld;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        logic [3:0] ctrl;
        logic signed [15:0] supVal;
        logic [14:0] supRate;
        logic [14:0] accTime;
        logic [14:0] decTime;
        logic [15:0] arrHold;
        logic [15:0] cmpHold;
        logic [15:0] filtTc;
        logic [15:0] encClrVal;
        logic signed [16:0] pending;
        logic [pss_pkg::ACC_W-1:0] acc;
        logic mergedStep;
        logic mergedDir;
        logic superposing;
        logic [15:0] msCnt;
        logic [3:0] tenCnt;
        pss_pkg::pss_pos_t pos;
        logic [15:0] posCnt;
        logic posComplete;
        logic orientComplete;
        logic [15:0] orientCnt;
        logic signed [15:0] winMain;
        logic signed [15:0] winCard;
        logic signed [31:0] speedFilt;
        logic [15:0] encCount;
    } pss_state_t;

    pss_state_t r_q;
    pss_state_t r_d;
    logic [pss_pkg::IN_W-1:0] pinVec;
    logic [pss_pkg::IN_W-1:0] rise;
    logic [pss_pkg::IN_W-1:0] lvl;

    assign pinVec = {encClear, orientDone, targetReached, posStart, termDecrease, termIncrease,
                     termOneShot, cardDir, cardPulse, refDir, refPulse};
    assign lvl = r_q.s2;
    assign rise = r_q.s2 & ~r_q.s3;

    function automatic logic isMapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= pss_pkg::OFF_ENCCNT;
    endfunction : isMapped

    function automatic logic [31:0] regRead(input pss_state_t s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case ({a[7:2], 2'h0})
            pss_pkg::OFF_CTRL: v = 32'(s.ctrl);
            pss_pkg::OFF_SUPVAL: v = 32'(signed'(s.supVal));
            pss_pkg::OFF_SUPRATE: v = 32'(s.supRate);
            pss_pkg::OFF_ACCTIME: v = 32'(s.accTime);
            pss_pkg::OFF_DECTIME: v = 32'(s.decTime);
            pss_pkg::OFF_ARRHOLD: v = 32'(s.arrHold);
            pss_pkg::OFF_CMPHOLD: v = 32'(s.cmpHold);
            pss_pkg::OFF_FILTTC: v = 32'(s.filtTc);
            pss_pkg::OFF_ENCCLR: v = 32'(s.encClrVal);
            pss_pkg::OFF_STATUS: begin
                v[pss_pkg::ST_SUPER] = s.superposing;
                v[pss_pkg::ST_STATE_LO +: 3] = s.pos;
                v[pss_pkg::ST_POSDONE] = s.posComplete;
                v[pss_pkg::ST_ORIDONE] = s.orientComplete;
                v[pss_pkg::ST_PEND_LO +: 16] = s.pending[15:0];
            end
            pss_pkg::OFF_SPEED: v = 32'(s.speedFilt >>> 8);
            pss_pkg::OFF_ENCCNT: v = 32'(s.encCount);
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : regRead

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                v[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return v;
    endfunction : merge

    function automatic int clampI(input int v, input int lo, input int hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampI

    // first-order filter as a shift: time constant in 0.1 ms, one sample per ms
    function automatic logic [4:0] filtShift(input logic [15:0] tc);
        logic [4:0] k;
        k = 5'h00;
        for (int i = 1; i < 12; i++) begin
            if (32'(tc) >= (32'd10 << i)) begin
                k = 5'(i);
            end
        end
        return k;
    endfunction : filtShift

    always_comb begin
        logic [31:0] wv;
        logic en;
        logic incOn;
        logic decOn;
        logic shotOn;
        logic active;
        logic injNeg;
        logic inject;
        logic [pss_pkg::ACC_W-1:0] sum;
        logic tickMs;
        logic tick10;
        logic signed [15:0] dMain;
        logic signed [15:0] dCard;
        logic signed [15:0] raw;
        logic signed [31:0] x;
        int pv;
        wv = 32'h0000_0000;
        pv = 0;
        r_d = r_q;
        r_d.s1 = pinVec;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;

        // write channel, address and data taken in either order
        if (s_axi_awvalid && r_q.awReady) begin
            r_d.awHeld = 1'b1;
            r_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r_q.wReady) begin
            r_d.wHeld = 1'b1;
            r_d.wData = s_axi_wdata;
            r_d.wStrb = s_axi_wstrb;
        end
        if (r_q.bValid && s_axi_bready) begin
            r_d.bValid = 1'b0;
        end
        if (r_d.awHeld && r_d.wHeld && !r_d.bValid) begin
            wv = merge(regRead(r_q, r_d.awAddr), r_d.wData, r_d.wStrb);
            r_d.bResp = isMapped(r_d.awAddr) ? pss_pkg::RESP_OKAY : pss_pkg::RESP_SLVERR;
            case (r_d.awAddr)
                pss_pkg::OFF_CTRL: r_d.ctrl = wv[3:0];
                pss_pkg::OFF_SUPVAL: r_d.supVal = 16'(clampI(int'(signed'(wv)), pss_pkg::SUPVAL_MIN,
                    pss_pkg::SUPVAL_MAX));
                pss_pkg::OFF_SUPRATE: r_d.supRate = 15'(clampI(int'(wv[16:0]), 0, pss_pkg::RATE_MAX));
                pss_pkg::OFF_ACCTIME: r_d.accTime = 15'(clampI(int'(wv[16:0]), pss_pkg::RAMP_MIN,
                    pss_pkg::RAMP_MAX));
                pss_pkg::OFF_DECTIME: r_d.decTime = 15'(clampI(int'(wv[16:0]), pss_pkg::RAMP_MIN,
                    pss_pkg::RAMP_MAX));
                pss_pkg::OFF_ARRHOLD: r_d.arrHold = 16'(clampI(int'(wv[16:0]), 0, pss_pkg::HOLD_MAX));
                pss_pkg::OFF_CMPHOLD: r_d.cmpHold = 16'(clampI(int'(wv[16:0]), 0, pss_pkg::HOLD_MAX));
                pss_pkg::OFF_FILTTC: r_d.filtTc = 16'(clampI(int'(wv[16:0]), 0, pss_pkg::FILT_MAX));
                pss_pkg::OFF_ENCCLR: r_d.encClrVal = wv[15:0];
                default: r_d.bResp = r_d.bResp;
            endcase
            r_d.awHeld = 1'b0;
            r_d.wHeld = 1'b0;
            r_d.bValid = 1'b1;
        end
        r_d.awReady = !r_d.awHeld && !r_d.bValid;
        r_d.wReady = !r_d.wHeld && !r_d.bValid;

        // read channel
        if (r_q.rValid && s_axi_rready) begin
            r_d.rValid = 1'b0;
        end
        if (s_axi_arvalid && r_q.arReady) begin
            r_d.rValid = 1'b1;
            r_d.rData = regRead(r_q, s_axi_araddr);
            r_d.rResp = isMapped(s_axi_araddr) ? pss_pkg::RESP_OKAY : pss_pkg::RESP_SLVERR;
        end
        r_d.arReady = !r_d.rValid;

        // time base
        tickMs = r_q.msCnt == 16'(MS_CYCLES - 1);
        tick10 = tickMs && r_q.tenCnt == 4'(pss_pkg::RAMP_UNIT_MS - 1);
        r_d.msCnt = tickMs ? 16'h0000 : r_q.msCnt + 16'h0001;
        if (tick10) begin
            r_d.tenCnt = 4'h0;
        end else if (tickMs) begin
            r_d.tenCnt = r_q.tenCnt + 4'h1;
        end

        // superposition
        en = r_q.ctrl[pss_pkg::CTRL_PULSE_REF] | r_q.ctrl[pss_pkg::CTRL_POS_MODE];
        incOn = en && lvl[pss_pkg::IN_INC] && !lvl[pss_pkg::IN_DEC];
        decOn = en && lvl[pss_pkg::IN_DEC] && !lvl[pss_pkg::IN_INC];
        shotOn = en && !lvl[pss_pkg::IN_INC] && !lvl[pss_pkg::IN_DEC] && r_q.pending != 17'sh00000;
        active = incOn || decOn || shotOn;
        injNeg = decOn || (shotOn && r_q.pending < 0);
        sum = r_q.acc + pss_pkg::ACC_W'(r_q.supRate);
        inject = 1'b0;
        if (!en) begin
            r_d.pending = 17'sh00000;
        end else if (rise[pss_pkg::IN_ONESHOT]) begin
            pv = clampI(int'(r_q.pending) + int'(r_q.supVal), -pss_pkg::PEND_LIM, pss_pkg::PEND_LIM);
            r_d.pending = 17'(pv);
        end
        if (!active) begin
            r_d.acc = '0;
        end else if (sum >= pss_pkg::ACC_W'(FULL)) begin
            // a received edge in the same cycle wins; the injection waits one cycle
            if (!rise[pss_pkg::IN_REF]) begin
                inject = 1'b1;
                r_d.acc = sum - pss_pkg::ACC_W'(FULL);
            end
        end else begin
            r_d.acc = sum;
        end
        if (inject && shotOn) begin
            r_d.pending = injNeg ? r_d.pending + 17'sh00001 : r_d.pending - 17'sh00001;
        end
        r_d.superposing = active;
        r_d.mergedStep = rise[pss_pkg::IN_REF] || inject;
        r_d.mergedDir = rise[pss_pkg::IN_REF] ? lvl[pss_pkg::IN_REFDIR] : !injNeg;

        // speed measurement and encoder count
        dMain = r_d.mergedStep ? (r_d.mergedDir ? 16'sh0001 : -16'sh0001) : 16'sh0000;
        dCard = rise[pss_pkg::IN_CARD] ? (lvl[pss_pkg::IN_CARDDIR] ? 16'sh0001 : -16'sh0001) : 16'sh0000;
        case (r_q.ctrl[pss_pkg::CTRL_SRC_LO +: 2])
            pss_pkg::SRC_CARD: raw = r_q.winCard;
            pss_pkg::SRC_HYBRID: raw = 16'((17'(r_q.winMain) + 17'(r_q.winCard)) >>> 1);
            default: raw = r_q.winMain;
        endcase
        x = 32'(raw) <<< 8;
        if (tickMs) begin
            if (r_q.filtTc == 16'h0000) begin
                r_d.speedFilt = x;
            end else begin
                r_d.speedFilt = r_q.speedFilt + ((x - r_q.speedFilt) >>> filtShift(r_q.filtTc));
            end
            r_d.winMain = dMain;
            r_d.winCard = dCard;
        end else begin
            r_d.winMain = r_q.winMain + dMain;
            r_d.winCard = r_q.winCard + dCard;
        end
        if (rise[pss_pkg::IN_ENCCLR]) begin
            r_d.encCount = r_q.encClrVal;
        end else begin
            r_d.encCount = r_q.encCount + 16'(dCard);
        end

        // positioning sequence
        case (r_q.pos)
            pss_pkg::POS_IDLE: begin
                if (rise[pss_pkg::IN_START]) begin
                    r_d.pos = pss_pkg::POS_ACCEL;
                    r_d.posCnt = 16'h0000;
                    r_d.posComplete = 1'b0;
                end
            end
            pss_pkg::POS_ACCEL: begin
                if (tick10) begin
                    r_d.posCnt = r_q.posCnt + 16'h0001;
                    if (r_q.posCnt >= 16'(r_q.accTime)) begin
                        r_d.pos = pss_pkg::POS_RUN;
                    end
                end
            end
            pss_pkg::POS_RUN: begin
                if (lvl[pss_pkg::IN_TARGET]) begin
                    r_d.pos = pss_pkg::POS_DECEL;
                    r_d.posCnt = 16'h0000;
                end
            end
            pss_pkg::POS_DECEL: begin
                if (tick10) begin
                    r_d.posCnt = r_q.posCnt + 16'h0001;
                    if (r_q.posCnt >= 16'(r_q.decTime)) begin
                        r_d.pos = pss_pkg::POS_ARRIVE;
                        r_d.posCnt = 16'h0000;
                    end
                end
            end
            pss_pkg::POS_ARRIVE: begin
                if (r_q.posCnt >= r_q.arrHold) begin
                    r_d.pos = pss_pkg::POS_COMPLETE;
                    r_d.posCnt = 16'h0000;
                    r_d.posComplete = 1'b1;
                end else if (tickMs) begin
                    r_d.posCnt = r_q.posCnt + 16'h0001;
                end
            end
            pss_pkg::POS_COMPLETE: begin
                if (r_q.posCnt >= r_q.cmpHold) begin
                    r_d.pos = pss_pkg::POS_IDLE;
                    r_d.posComplete = 1'b0;
                end else if (tickMs) begin
                    r_d.posCnt = r_q.posCnt + 16'h0001;
                end
            end
            default: r_d.pos = pss_pkg::POS_IDLE;
        endcase

        // orientation completion shares the completion hold time
        if (rise[pss_pkg::IN_ORIENT]) begin
            r_d.orientComplete = 1'b1;
            r_d.orientCnt = 16'h0000;
        end else if (r_q.orientComplete) begin
            if (r_q.orientCnt >= r_q.cmpHold) begin
                r_d.orientComplete = 1'b0;
            end else if (tickMs) begin
                r_d.orientCnt = r_q.orientCnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r_q <= '0;
            r_q.supRate <= pss_pkg::RST_SUPRATE;
            r_q.accTime <= pss_pkg::RST_ACCTIME;
            r_q.decTime <= pss_pkg::RST_DECTIME;
            r_q.arrHold <= pss_pkg::RST_ARRHOLD;
            r_q.cmpHold <= pss_pkg::RST_CMPHOLD;
            r_q.filtTc <= pss_pkg::RST_FILTTC;
        end else begin
            r_q <= r_d;
        end
    end

    assign s_axi_awready = r_q.awReady;
    assign s_axi_wready = r_q.wReady;
    assign s_axi_bresp = r_q.bResp;
    assign s_axi_bvalid = r_q.bValid;
    assign s_axi_arready = r_q.arReady;
    assign s_axi_rdata = r_q.rData;
    assign s_axi_rresp = r_q.rResp;
    assign s_axi_rvalid = r_q.rValid;
    assign mergedStep = r_q.mergedStep;
    assign mergedDir = r_q.mergedDir;
    assign superposing = r_q.superposing;
    assign posComplete = r_q.posComplete;
    assign orientComplete = r_q.orientComplete;
endmodule : pss_core

// File: test/pss_chk.sv
// port assertions for the superposition block
`timescale 1ns/1ps
module pss_chk #(
    parameter int unsigned MS_CYCLES = pss_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic refPulse,
    input wire logic termIncrease,
    input wire logic termDecrease,
    input wire logic orientDone,
    input wire logic mergedStep,
    input wire logic mergedDir,
    input wire logic superposing,
    input wire logic posComplete,
    input wire logic orientComplete
);
    // completion hold at its reset value, converted from ms ticks to clock cycles
    localparam int HOLD = int'(pss_pkg::RST_CMPHOLD) * MS_CYCLES;
    int posCnt_q;
    int oriCnt_q;
    logic [3:0] quiet_q;
    logic [2:0] prev_q;
    // quiet_q counts cycles, up to 15, since refPulse, termIncrease or termDecrease last changed
    always_ff @(posedge clk) begin
        prev_q <= {refPulse, termIncrease, termDecrease};
        if (!reset_n) begin
            posCnt_q <= 0;
            oriCnt_q <= 0;
            quiet_q <= 4'h0;
        end else begin
            posCnt_q <= posComplete ? posCnt_q + 1 : 0;
            oriCnt_q <= orientComplete ? oriCnt_q + 1 : 0;
            if (prev_q != {refPulse, termIncrease, termDecrease}) quiet_q <= 4'h0;
            else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer missing");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
        else $error("read answer changed");
    a_inject_dir: assert property (quiet_q == 4'hF && termIncrease != termDecrease && mergedStep |-> mergedDir == termIncrease)
        else $error("injected step has wrong direction");
    a_inject_flag: assert property (quiet_q == 4'hF && termIncrease && !termDecrease && mergedStep |-> superposing)
        else $error("injection without superposing flag");
    a_pos_hold: assert property ($fell(posComplete) |-> posCnt_q >= HOLD && posCnt_q <= HOLD + 1)
        else $error("completion hold length wrong");
    a_orient_hold: assert property ($fell(orientComplete) |-> oriCnt_q >= HOLD - MS_CYCLES + 2 && oriCnt_q <= HOLD + 1)
        else $error("orientation hold length wrong");
    a_orient_start: assert property ($rose(orientDone) |-> ##[2:6] orientComplete)
        else $error("orientation completion missing");
endmodule : pss_chk

bind pss_core pss_chk #(.MS_CYCLES(MS_CYCLES)) chk (.*);

// File: test/pss_ext.sv
// external controller sending reference pulse bursts
`timescale 1ns/1ps
module pss_ext (
    // control from bench
    input wire logic clk,
    input wire logic extGo,
    input wire logic [7:0] extNum,
    input wire logic extDir,
    // pulse lines
    output logic refPulse,
    output logic refDir,
    output logic cardPulse,
    output logic cardDir
);
    int left;
    int ph;
    initial begin
        {refPulse, refDir, cardPulse, cardDir} = 4'h1;
        left = 0;
        ph = 0;
    end
    // three cycles high, three low per pulse
    always @(posedge clk) begin
        if (extGo && left == 0) begin
            left <= extNum;
            refDir <= extDir;
            cardDir <= !extDir;
            ph <= 0;
        end else if (left != 0) begin
            ph <= (ph == 5) ? 0 : ph + 1;
            refPulse <= ph < 3;
            cardPulse <= ph < 3;
            if (ph == 5) left <= left - 1;
        end else begin
            refPulse <= 1'b0;
            cardPulse <= 1'b0;
        end
    end
endmodule : pss_ext

// File: test/testbench.sv
// self-checking bench for the superposition block
`timescale 1ns/1ps
module testbench;
    localparam logic [1:0] OK = pss_pkg::RESP_OKAY;
    localparam logic [1:0] ER = pss_pkg::RESP_SLVERR;
    logic clk = 0, reset_n = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, extNum = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h0000005A;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic refPulse, refDir, cardPulse, cardDir, extGo = 0, extDir = 0;
    logic termOneShot = 0, termIncrease = 0, termDecrease = 0;
    logic posStart = 0, targetReached = 0, orientDone = 0, encClear = 0;
    logic mergedStep, mergedDir, superposing, posComplete, orientComplete;
    logic [33:0] rq[$], bq[$];
    int fail_count = 0, compares = 0, pos = 0, neg = 0;
    always #25 clk = ~clk;
    pss_core #(.MS_CYCLES(20)) dut (.*);
    pss_ext ext (.*);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic chk_bus(input logic [33:0] e, input logic [33:0] a);
        compares++;
        if (a !== e) begin
            fail_count++;
            $display("Error %0t exp %h got %h", $time, e, a);
        end
    endtask : chk_bus
    task automatic cnt(input logic [31:0] v, input int lo, input int hi);
        compares++;
        if ((v >= lo && v <= hi) !== 1'b1) begin
            fail_count++;
            $display("Error %0t exp %h..%h got %h", $time, lo, hi, v);
        end
    endtask : cnt
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back({r, 32'h0});
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask : rd
    // hold terminals t for n cycles, then count steps of direction d
    task automatic run(input logic [2:0] t, input int n, input int lo, input int hi, input logic d);
        int p0, n0;
        p0 = pos;
        n0 = neg;
        @(posedge clk);
        {termDecrease, termIncrease, termOneShot} <= t;
        repeat (n) @(posedge clk);
        cnt(32'(superposing), lo > 0, lo > 0);
        {termDecrease, termIncrease, termOneShot} <= 3'h0;
        for (int i = 0; i < 3000 && superposing !== 1'b0; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        cnt(d ? pos - p0 : neg - n0, lo, hi);
        cnt(d ? neg - n0 : pos - p0, 0, 0);
        cnt(32'(superposing), 0, 0);
    endtask : run
    task automatic summarize();
        if (fail_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) chk_bus(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) chk_bus(bq.pop_front(), {s_axi_bresp, 32'h0});
        if (mergedStep === 1'b1) begin
            if (mergedDir) pos++;
            else neg++;
        end
    end
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        summarize();
    end
    initial begin
        int k, p, i;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(pss_pkg::OFF_CTRL, 32'h0, OK);
        rd(pss_pkg::OFF_SUPVAL, 32'h0, OK);
        rd(pss_pkg::OFF_SUPRATE, 32'h50, OK);
        rd(pss_pkg::OFF_DECTIME, 32'h12C, OK);
        rd(pss_pkg::OFF_ARRHOLD, 32'h64, OK);
        rd(pss_pkg::OFF_CMPHOLD, 32'hC8, OK);
        rd(pss_pkg::OFF_FILTTC, 32'h64, OK);
        rd(pss_pkg::OFF_ENCCLR, 32'h0, OK);
        rd(8'h30, 32'h0, ER);
        wr(8'h06, 32'h1, ER);
        wr(pss_pkg::OFF_STATUS, 32'hFFFFFFFF, OK);
        wr(pss_pkg::OFF_SUPRATE, 32'h14, OK);
        run(3'h2, 200, 0, 0, 1'b1);
        wr(pss_pkg::OFF_CTRL, 32'h9, OK);
        rd(pss_pkg::OFF_CTRL, 32'h9, OK);
        wr(pss_pkg::OFF_SUPVAL, 32'h9C40, OK);
        rd(pss_pkg::OFF_SUPVAL, 32'h7FFF, OK);
        wr(pss_pkg::OFF_SUPVAL, 32'hFFFFB1E0, OK);
        rd(pss_pkg::OFF_SUPVAL, 32'hFFFFD8F1, OK);
        wr(pss_pkg::OFF_ACCTIME, 32'h0, OK);
        rd(pss_pkg::OFF_ACCTIME, 32'h1, OK);
        wr(pss_pkg::OFF_FILTTC, 32'h9C40, OK);
        rd(pss_pkg::OFF_FILTTC, 32'h7D00, OK);
        wr(pss_pkg::OFF_ARRHOLD, 32'h11170, OK);
        rd(pss_pkg::OFF_ARRHOLD, 32'hEA60, OK);
        wr(pss_pkg::OFF_DECTIME, 32'h1, OK);
        wr(pss_pkg::OFF_ARRHOLD, 32'h5, OK);
        run(3'h2, 200, 17, 21, 1'b1);
        run(3'h4, 200, 17, 21, 1'b0);
        run(3'h6, 100, 0, 0, 1'b1);
        seed = xs(seed);
        k = seed % 9 + 1;
        wr(pss_pkg::OFF_SUPVAL, 32'(k), OK);
        run(3'h1, 6, k, k, 1'b1);
        seed = xs(seed);
        k = seed % 9 + 1;
        wr(pss_pkg::OFF_SUPVAL, -32'(k), OK);
        run(3'h1, 6, k, k, 1'b0);
        p = pos;
        extNum <= 8'h05;
        extDir <= 1'b1;
        extGo <= 1'b1;
        @(posedge clk);
        extGo <= 1'b0;
        repeat (40) @(posedge clk);
        cnt(pos - p, 5, 5);
        posStart <= 1'b1;
        repeat (410) @(posedge clk);
        targetReached <= 1'b1;
        for (i = 0; i < 2000 && posComplete !== 1'b1; i++) @(posedge clk);
        cnt(i, 306, 505);
        rd(pss_pkg::OFF_STATUS, 32'h1A, OK);
        {posStart, targetReached, orientDone} <= 3'h1;
        for (i = 0; i < 9000 && (posComplete | orientComplete) !== 1'b0; i++) @(posedge clk);
        orientDone <= 1'b0;
        wr(pss_pkg::OFF_ENCCLR, 32'h1234, OK);
        encClear <= 1'b1;
        repeat (8) @(posedge clk);
        rd(pss_pkg::OFF_ENCCNT, 32'h1234, OK);
        summarize();
    end
endmodule : testbench
